// [hdl/uif_consts.vh]
// Constants for the UART interrupt-flag and receive-timeout block.
// Assumes byte addressing on a 32-bit classic Wishbone bus.
`ifndef UIF_CONSTS_VH
`define UIF_CONSTS_VH

// Register byte offsets.
`define UIF_OFS_DATA 8'h00
`define UIF_OFS_IRQ_ENABLE 8'h04
`define UIF_OFS_FIFO_CONTROL 8'h08
`define UIF_OFS_FIFO_STATUS 8'h18
`define UIF_OFS_IRQ_STATUS 8'h1C
`define UIF_OFS_TIMEOUT_GAP 8'h20

// Reset values.
`define UIF_RST_TIMEOUT_GAP 16'h0000
`define UIF_RST_IRQ_ENABLE 6'h00
`define UIF_RST_TRIGGER 4'h1
`define UIF_RST_COMPARE 8'h00
`define UIF_RST_GAP 8'h00

// Interrupt status and enable bit positions.
`define UIF_BIT_RX_LEVEL 0
`define UIF_BIT_TX_EMPTY 1
`define UIF_BIT_LINE 2
`define UIF_BIT_RX_IDLE 4
`define UIF_BIT_TIMER_EN 11
`define UIF_BIT_IRQ_STAT_OFS 8

// Timeout and gap fields.
`define UIF_COMPARE_LSB 0
`define UIF_GAP_LSB 8

// Fifo control fields.
`define UIF_TRIGGER_LSB 4
`define UIF_BIT_RS485 8

// Fifo status bit positions of the incoming receive status bits.
`define UIF_BIT_ADDR_DET 3
`define UIF_BIT_PARITY 4
`define UIF_BIT_FRAMING 5
`define UIF_BIT_BREAK 6

`endif

// [hdl/uif_idle_timer.v]
// Receive idle counter that ticks once per bit time.
// Assumes bit_tick is a one-cycle pulse at the baud rate.
`timescale 1ns/100ps
`default_nettype none
module uif_idle_timer #(
  parameter CW = 8
) (
  input wire core_clk,
  input wire rst,
  input wire enable,
  input wire bit_tick,
  input wire restart,
  input wire [CW-1:0] compare,
  output reg hit_ff
);

  reg [CW-1:0] count_ff;
  reg [CW-1:0] nxt_count;
  reg nxt_hit;

  // The counter stops at the compare value so that it fires only once per idle stretch.
  always @* begin
    nxt_count = count_ff;
    nxt_hit = 1'b0;
    if (!enable || restart) begin
      nxt_count = {CW{1'b0}};
    end else if (bit_tick && count_ff != compare) begin
      nxt_count = count_ff + 1'b1;
      nxt_hit = (count_ff + 1'b1) == compare;
    end
  end

  // Counter and hit pulse registers.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= {CW{1'b0}};
      hit_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      hit_ff <= nxt_hit;
    end
  end

endmodule
`default_nettype wire

// [hdl/uif_tx_gap.v]
// Transmit gap timer inserting idle bit times after each stop bit.
// Assumes stop_done pulses once when a frame's last stop bit ends.
`timescale 1ns/100ps
`default_nettype none
module uif_tx_gap #(
  parameter GW = 8
) (
  input wire core_clk,
  input wire rst,
  input wire bit_tick,
  input wire stop_done,
  input wire [GW-1:0] gap_bits,
  output reg hold_ff
);

  reg [GW-1:0] left_ff;
  reg [GW-1:0] nxt_left;
  reg nxt_hold;

  // A zero gap never raises hold, so back-to-back frames stay possible.
  always @* begin
    nxt_left = left_ff;
    nxt_hold = hold_ff;
    if (stop_done) begin
      nxt_left = gap_bits;
      nxt_hold = gap_bits != {GW{1'b0}};
    end else if (hold_ff && bit_tick) begin
      nxt_left = left_ff - 1'b1;
      nxt_hold = left_ff != {{(GW-1){1'b0}}, 1'b1};
    end
  end

  // Gap counter registers.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      left_ff <= {GW{1'b0}};
      hold_ff <= 1'b0;
    end else begin
      left_ff <= nxt_left;
      hold_ff <= nxt_hold;
    end
  end

endmodule
`default_nettype wire

// [hdl/uif_top.v]
// UART interrupt flags, receive idle timeout and transmit gap, with a Wishbone register slave.
// Assumes the queues, shifters and baud generator live outside and report through single-cycle pulses, the queue count and sticky flags.
//
// The implementer's own choice: the Wishbone slave port.
`include "uif_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module uif_top #(
  parameter CW = 5,
  parameter DW = 8
) (
  input wire core_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire bit_tick,
  input wire tx_last_loaded,
  input wire tx_stop_done,
  input wire rx_word_push,
  input wire [CW-1:0] rx_count,
  input wire [DW-1:0] rx_data,
  input wire rx_active,
  input wire break_flag,
  input wire framing_error_flag,
  input wire parity_error_flag,
  input wire address_byte_detect_flag,
  output reg [DW-1:0] tx_data_ff,
  output reg tx_write_ff,
  output reg rx_pop_ff,
  output reg tx_gap_hold,
  output reg irq_ff
);

  // Software-written control state.
  reg [7:0] rx_idle_compare_ff;
  reg [7:0] tx_gap_bit_times_ff;
  reg tx_holding_empty_irq_enable_ff;
  reg rx_level_irq_enable_ff;
  reg line_irq_enable_ff;
  reg rx_idle_irq_enable_ff;
  reg idle_timer_enable_ff;
  reg [3:0] rx_trigger_level_ff;
  reg rs485_mode_ff;

  // Hardware-owned flags.
  reg tx_holding_empty_flag_ff;
  reg rx_level_flag_ff;
  reg line_status_flag_ff;
  reg rx_idle_flag_ff;

  // Bus decode.
  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  wire sel_data;
  wire sel_enable;
  wire sel_control;
  wire sel_fstatus;
  wire sel_status;
  wire sel_timeout;
  wire idle_hit;
  wire gap_hold;
  wire rx_empty;
  wire thr_write;
  wire rbr_read;

  reg nxt_tx_empty;
  reg nxt_rx_level;
  reg nxt_line;
  reg nxt_rx_idle;
  reg [31:0] nxt_rdata;
  reg [4:0] enabled_flags;

  // True when a byte address selects the given register word.
  function hit_word;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit_word = adr[7:2] == ofs[7:2];
    end
  endfunction

  // A request is taken once, in the cycle before the ack is raised, so side effects never repeat.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;
  assign sel_data = hit_word(wb_adr_i, `UIF_OFS_DATA);
  assign sel_enable = hit_word(wb_adr_i, `UIF_OFS_IRQ_ENABLE);
  assign sel_control = hit_word(wb_adr_i, `UIF_OFS_FIFO_CONTROL);
  assign sel_fstatus = hit_word(wb_adr_i, `UIF_OFS_FIFO_STATUS);
  assign sel_status = hit_word(wb_adr_i, `UIF_OFS_IRQ_STATUS);
  assign sel_timeout = hit_word(wb_adr_i, `UIF_OFS_TIMEOUT_GAP);
  // The holding register takes a byte only when lane 0 is enabled.
  assign thr_write = bus_wr & sel_data & wb_sel_i[0];
  assign rbr_read = bus_rd & sel_data;
  // An empty queue stops the idle counter and clears the timeout flag.
  assign rx_empty = rx_count == {CW{1'b0}};

  // Idle counter; it runs only while enabled and the receive queue holds data.
  uif_idle_timer #(
    .CW(8)
  ) u_idle (
    .core_clk(core_clk),
    .rst(rst),
    .enable(idle_timer_enable_ff & ~rx_empty),
    .bit_tick(bit_tick),
    .restart(rx_word_push),
    .compare(rx_idle_compare_ff),
    .hit_ff(idle_hit)
  );

  // Gap timer between the stop bit of one frame and the next start bit.
  uif_tx_gap #(
    .GW(8)
  ) u_gap (
    .core_clk(core_clk),
    .rst(rst),
    .bit_tick(bit_tick),
    .stop_done(tx_stop_done),
    .gap_bits(tx_gap_bit_times_ff),
    .hold_ff(gap_hold)
  );

  // Flag next-state logic; in every flag the hardware set wins over a clear in the same cycle, except the empty-queue clear of the idle flag.
  always @* begin
    nxt_tx_empty = tx_holding_empty_flag_ff;
    if (thr_write) begin
      nxt_tx_empty = 1'b0;
    end
    if (tx_last_loaded) begin
      nxt_tx_empty = 1'b1;
    end
    // The level flag holds while the count stays at or above the trigger.
    nxt_rx_level = (rx_count == {{(CW-4){1'b0}}, rx_trigger_level_ff})
      | (rx_level_flag_ff & (rx_count >= {{(CW-4){1'b0}}, rx_trigger_level_ff}));
    // The line flag mirrors the sticky error bits, plus the address-detect bit in RS-485 mode; software clears them elsewhere.
    if (rs485_mode_ff) begin
      nxt_line = break_flag | framing_error_flag | parity_error_flag | address_byte_detect_flag;
    end else begin
      nxt_line = break_flag | framing_error_flag | parity_error_flag;
    end
    // Clears are applied first so that a timeout hit in the same cycle still wins, except when the receive queue is empty.
    nxt_rx_idle = rx_idle_flag_ff;
    if (rx_word_push || rx_empty) begin
      nxt_rx_idle = 1'b0;
    end
    if (rbr_read && rx_active) begin
      nxt_rx_idle = 1'b0;
    end
    if (idle_hit && !rx_empty) begin
      nxt_rx_idle = 1'b1;
    end
  end

  // Enabled flag vector feeding the interrupt status and the interrupt output.
  always @* begin
    enabled_flags = 5'h00;
    enabled_flags[`UIF_BIT_RX_LEVEL] = rx_level_flag_ff & rx_level_irq_enable_ff;
    enabled_flags[`UIF_BIT_TX_EMPTY] = tx_holding_empty_flag_ff & tx_holding_empty_irq_enable_ff;
    enabled_flags[`UIF_BIT_LINE] = line_status_flag_ff & line_irq_enable_ff;
    enabled_flags[`UIF_BIT_RX_IDLE] = rx_idle_flag_ff & rx_idle_irq_enable_ff;
  end

  // Read mux; unmapped addresses read as zero and are still acknowledged.
  always @* begin
    nxt_rdata = 32'h00000000;
    if (sel_data) begin
      nxt_rdata[DW-1:0] = rx_data;
    end else if (sel_enable) begin
      nxt_rdata[`UIF_BIT_RX_LEVEL] = rx_level_irq_enable_ff;
      nxt_rdata[`UIF_BIT_TX_EMPTY] = tx_holding_empty_irq_enable_ff;
      nxt_rdata[`UIF_BIT_LINE] = line_irq_enable_ff;
      nxt_rdata[`UIF_BIT_RX_IDLE] = rx_idle_irq_enable_ff;
      nxt_rdata[`UIF_BIT_TIMER_EN] = idle_timer_enable_ff;
    end else if (sel_control) begin
      nxt_rdata[`UIF_TRIGGER_LSB+3:`UIF_TRIGGER_LSB] = rx_trigger_level_ff;
      nxt_rdata[`UIF_BIT_RS485] = rs485_mode_ff;
    end else if (sel_fstatus) begin
      nxt_rdata[`UIF_BIT_ADDR_DET] = address_byte_detect_flag;
      nxt_rdata[`UIF_BIT_PARITY] = parity_error_flag;
      nxt_rdata[`UIF_BIT_FRAMING] = framing_error_flag;
      nxt_rdata[`UIF_BIT_BREAK] = break_flag;
    end else if (sel_status) begin
      // Reading status only samples the flags; nothing is cleared by it.
      nxt_rdata[`UIF_BIT_RX_LEVEL] = rx_level_flag_ff;
      nxt_rdata[`UIF_BIT_TX_EMPTY] = tx_holding_empty_flag_ff;
      nxt_rdata[`UIF_BIT_LINE] = line_status_flag_ff;
      nxt_rdata[`UIF_BIT_RX_IDLE] = rx_idle_flag_ff;
      nxt_rdata[`UIF_BIT_IRQ_STAT_OFS+4:`UIF_BIT_IRQ_STAT_OFS] = enabled_flags;
    end else if (sel_timeout) begin
      nxt_rdata[`UIF_COMPARE_LSB+7:`UIF_COMPARE_LSB] = rx_idle_compare_ff;
      nxt_rdata[`UIF_GAP_LSB+7:`UIF_GAP_LSB] = tx_gap_bit_times_ff;
    end
  end

  // Bus answer registers: ack one cycle after the request is seen, dropped the cycle after.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= nxt_rdata;
      end
    end
  end

  // Software-writable control registers, honouring byte lanes; the status word has no write path.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // A zero compare never fires, so the timeout stays silent until software programs it.
      rx_idle_compare_ff <= `UIF_RST_COMPARE;
      tx_gap_bit_times_ff <= `UIF_RST_GAP;
      {idle_timer_enable_ff, rx_idle_irq_enable_ff, line_irq_enable_ff} <= 3'h0;
      {tx_holding_empty_irq_enable_ff, rx_level_irq_enable_ff} <= 2'h0;
      rx_trigger_level_ff <= `UIF_RST_TRIGGER;
      rs485_mode_ff <= 1'b0;
    end else if (bus_wr) begin
      // Only lanes 0 and 1 carry fields; bytes on lanes 2 and 3 are dropped.
      if (sel_timeout && wb_sel_i[0]) begin
        rx_idle_compare_ff <= wb_dat_i[`UIF_COMPARE_LSB+7:`UIF_COMPARE_LSB];
      end
      if (sel_timeout && wb_sel_i[1]) begin
        tx_gap_bit_times_ff <= wb_dat_i[`UIF_GAP_LSB+7:`UIF_GAP_LSB];
      end
      if (sel_enable && wb_sel_i[0]) begin
        rx_level_irq_enable_ff <= wb_dat_i[`UIF_BIT_RX_LEVEL];
        tx_holding_empty_irq_enable_ff <= wb_dat_i[`UIF_BIT_TX_EMPTY];
        line_irq_enable_ff <= wb_dat_i[`UIF_BIT_LINE];
        rx_idle_irq_enable_ff <= wb_dat_i[`UIF_BIT_RX_IDLE];
      end
      if (sel_enable && wb_sel_i[1]) begin
        idle_timer_enable_ff <= wb_dat_i[`UIF_BIT_TIMER_EN];
      end
      if (sel_control && wb_sel_i[0]) begin
        rx_trigger_level_ff <= wb_dat_i[`UIF_TRIGGER_LSB+3:`UIF_TRIGGER_LSB];
      end
      if (sel_control && wb_sel_i[1]) begin
        rs485_mode_ff <= wb_dat_i[`UIF_BIT_RS485];
      end
    end
  end

  // Flag registers; only hardware events and the documented side effects move them.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_holding_empty_flag_ff <= 1'b0;
      rx_level_flag_ff <= 1'b0;
      line_status_flag_ff <= 1'b0;
      rx_idle_flag_ff <= 1'b0;
    end else begin
      tx_holding_empty_flag_ff <= nxt_tx_empty;
      rx_level_flag_ff <= nxt_rx_level;
      line_status_flag_ff <= nxt_line;
      rx_idle_flag_ff <= nxt_rx_idle;
    end
  end

  // Strobes toward the queues, the gap hold and the interrupt, all straight from flip-flops.
  // The interrupt lags the flags by one cycle, traded for a glitch-free registered output.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_data_ff <= {DW{1'b0}};
      tx_write_ff <= 1'b0;
      rx_pop_ff <= 1'b0;
      tx_gap_hold <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      tx_write_ff <= thr_write;
      if (thr_write) begin
        tx_data_ff <= wb_dat_i[DW-1:0];
      end
      // The head byte was latched into the read data on this edge, so the queue may advance now.
      rx_pop_ff <= rbr_read;
      tx_gap_hold <= gap_hold;
      irq_ff <= |enabled_flags;
    end
  end

endmodule
`default_nettype wire

// [tb/uif_far_model.sv]
// Model of the queue side: baud ticks, rx queue count and head byte.
// Assumes push_req pulses one cycle per received word.
`timescale 1ns/100ps
`default_nettype none
module uif_far_model #(
  parameter TICK_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic push_req,
  input wire logic rx_pop_ff,
  output logic bit_tick,
  output logic rx_word_push,
  output logic [4:0] rx_count,
  output logic [7:0] rx_data
);
  logic [7:0] div_ff;
  // The head byte moves on every pop so a stale value never reads back.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_ff <= 8'h00;
      bit_tick <= 1'b0;
      rx_word_push <= 1'b0;
      rx_count <= 5'h00;
      rx_data <= 8'h5A;
    end else begin
      div_ff <= (div_ff == TICK_DIV - 1) ? 8'h00 : div_ff + 8'h01;
      bit_tick <= (div_ff == TICK_DIV - 1);
      rx_word_push <= push_req;
      rx_count <= rx_count + {4'h0, push_req} - {4'h0, rx_pop_ff && rx_count != 5'h00};
      if (rx_pop_ff) rx_data <= rx_data + 8'h35;
    end
  end
endmodule
`default_nettype wire

// [tb/uif_top_sva.sv]
// Checker on the ports of uif_top.
// Assumes a classic Wishbone master and registered outputs.
`timescale 1ns/100ps
`default_nettype none
module uif_chk (
  input wire core_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire bit_tick,
  input wire tx_stop_done,
  input wire [7:0] tx_data_ff,
  input wire tx_write_ff,
  input wire rx_pop_ff,
  input wire tx_gap_hold,
  input wire irq_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A taken request and its data-register read flavour.
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd0 = req & ~wb_we_i & (wb_adr_i[7:2] == 6'h00);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_time_a: assert property (req |=> wb_ack_o) else $error("request not acked");
  tx_write_a: assert property (req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] |=>
    tx_write_ff && tx_data_ff == $past(wb_dat_i[7:0])) else $error("tx byte not passed");
  pop_read_a: assert property (rd0 |=> rx_pop_ff) else $error("no pop on data read");
  pop_cause_a: assert property (rx_pop_ff |-> $past(rd0)) else $error("pop without read");
  gap_rise_a: assert property ($rose(tx_gap_hold) |-> $past(tx_stop_done, 2)) else $error("gap rose early");
  gap_fall_a: assert property ($fell(tx_gap_hold) |-> $past(bit_tick, 2)) else $error("gap end off tick");
  unmapped_a: assert property (req && !wb_we_i && wb_adr_i >= 8'h24 |=> wb_dat_o == 32'h0) else $error("unmapped read");
  rst_quiet_a: assert property ($fell(rst) |-> !irq_ff && !tx_gap_hold && !wb_ack_o) else $error("outputs after reset");
endmodule
bind uif_top uif_chk chk_u (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .bit_tick, .tx_stop_done, .tx_data_ff, .tx_write_ff, .rx_pop_ff,
  .tx_gap_hold, .irq_ff);
`default_nettype wire

// [tb/uif_top_tb_top.sv]
// Self-checking bench for uif_top with the queue-side model.
// Assumes one 50 MHz clock and a baud tick every four cycles.
`timescale 1ns/100ps
`default_nettype none
module uif_top_tb_top;
  logic core_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00, rx_data, tx_data_ff;
  logic [3:0] wb_sel_i = 4'hF, sel_v = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, bit_tick, rx_word_push, tx_write_ff, rx_pop_ff, tx_gap_hold, irq_ff;
  logic tx_last_loaded = 0, tx_stop_done = 0, rx_active = 0, push_req = 0;
  logic break_flag = 0, framing_error_flag = 0, parity_error_flag = 0, address_byte_detect_flag = 0;
  logic [4:0] rx_count;
  integer bad_count = 0, tests_run = 0, seed = 78233, t, k, n, g, trig, wd;
  always #10 core_clk = ~core_clk;
  uif_top dut_u (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .bit_tick, .tx_last_loaded, .tx_stop_done, .rx_word_push, .rx_count,
    .rx_data, .rx_active, .break_flag, .framing_error_flag, .parity_error_flag,
    .address_byte_detect_flag, .tx_data_ff, .tx_write_ff, .rx_pop_ff, .tx_gap_hold, .irq_ff);
  uif_far_model #(.TICK_DIV(4)) far_u (.core_clk, .rst, .push_req, .rx_pop_ff, .bit_tick,
    .rx_word_push, .rx_count, .rx_data);
  task finish_test;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, sel_v};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: no ack", $time);
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task push;
    @(posedge core_clk);
    push_req <= 1;
    @(posedge core_clk);
    push_req <= 0;
  endtask
  // Reads the data register until the queue is empty; a queue that never drains is a mismatch.
  task drain;
    for (t = 0; t < 20 && rx_count !== 5'h00; t++) bus(0, 8'h00, 0);
    chk(rx_count, 5'h00);
  endtask
  // Expected status word: raw flags low, flag and enable from bit 8.
  function [31:0] st(input [4:0] f, input [4:0] e);
    st = {19'h0, f & e, 3'h0, f};
  endfunction
  // Watchdog sized well above the whole sequence.
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    bus(0, 8'h20, 0); chk(q, 32'h0);
    bus(0, 8'h1C, 0); chk(q, st(0, 0));
    bus(1, 8'h40, 32'hFFFFFFFF); bus(0, 8'h40, 0); chk(q, 32'h0);
    n = 40 + {$random(seed)} % 216;
    g = 1 + {$random(seed)} % 5;
    bus(1, 8'h20, {g[7:0], n[7:0]}); bus(0, 8'h20, 0); chk(q, {g[7:0], n[7:0]});
    @(posedge core_clk) tx_stop_done <= 1;
    @(posedge core_clk) tx_stop_done <= 0;
    t = 0;
    while (tx_gap_hold !== 1'b1 && t < 9) begin @(posedge core_clk); t++; end
    t = 0;
    while (tx_gap_hold === 1'b1 && t < 99) begin @(posedge core_clk); t++; end
    chk(t >= (g - 1) * 4 + 1 && t <= g * 4 + 2, 1);
    sel_v = 4'h2;
    bus(1, 8'h20, 32'h0);
    sel_v = 4'hF;
    bus(0, 8'h20, 0); chk(q, {24'h0, n[7:0]});
    bus(1, 8'h04, 32'h2);
    @(posedge core_clk) tx_last_loaded <= 1;
    @(posedge core_clk) tx_last_loaded <= 0;
    bus(0, 8'h1C, 0); chk(q, st(5'h02, 5'h02));
    chk(irq_ff, 1);
    bus(1, 8'h1C, 0); bus(0, 8'h1C, 0); chk(q, st(5'h02, 5'h02));
    wd = $random(seed);
    bus(1, 8'h00, wd); chk(tx_data_ff, wd[7:0]);
    bus(0, 8'h1C, 0); chk(q, st(0, 5'h02));
    chk(irq_ff, 0);
    trig = 1 + {$random(seed)} % 8;
    bus(1, 8'h08, trig << 4); bus(1, 8'h04, 32'h5);
    repeat (trig - 1) push;
    bus(0, 8'h1C, 0); chk(q[0], 0);
    push;
    bus(0, 8'h1C, 0); chk(q, st(5'h01, 5'h05));
    bus(0, 8'h00, 0); chk(q, 32'h5A);
    bus(0, 8'h1C, 0); chk(q[0], 0);
    for (t = 0; t < 3; t++) begin
      {break_flag, framing_error_flag, parity_error_flag} <= 3'b100 >> t;
      bus(0, 8'h1C, 0); chk(q[2], 1);
    end
    parity_error_flag <= 0;
    bus(0, 8'h1C, 0); chk(q[2], 0);
    bus(1, 8'h08, 32'h100 | (trig << 4));
    {parity_error_flag, address_byte_detect_flag} <= 2'b11;
    bus(0, 8'h1C, 0); chk(q[2], 1);
    parity_error_flag <= 0;
    bus(0, 8'h1C, 0); chk(q[2], 1);
    address_byte_detect_flag <= 0;
    bus(0, 8'h1C, 0); chk(q[2], 0);
    drain;
    bus(1, 8'h20, 32'd40); bus(1, 8'h04, 32'h810);
    push; push;
    repeat (120) @(posedge core_clk);
    bus(0, 8'h1C, 0); chk(q[4], 0);
    repeat (60) @(posedge core_clk);
    bus(0, 8'h1C, 0); chk(q[4], 1);
    chk(irq_ff, 1);
    push;
    bus(0, 8'h1C, 0); chk(q[4], 0);
    repeat (180) @(posedge core_clk);
    bus(0, 8'h1C, 0); chk(q[4], 1);
    rx_active <= 1;
    bus(0, 8'h00, 0); bus(0, 8'h1C, 0); chk(q[4], 0);
    rx_active <= 0;
    push;
    repeat (200) @(posedge core_clk);
    bus(0, 8'h1C, 0); chk(q[4], 1);
    drain;
    bus(0, 8'h1C, 0); chk(q[4], 0);
    finish_test;
  end
endmodule
`default_nettype wire
